//--- rtl/ttc_pkg.sv
/*
 * Shared constants, types and helpers for the thermostat conversion
 * control block: command bytes, configuration bit layout, reset values,
 * timing counts and the event carrier between bus slave and core.
 * Assumes a 20 MHz system clock.
 */
`default_nettype none

package ttc_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned NVM_WRITE_MS = 10;
  // Longest time, so the cycle count rounds down
  localparam int unsigned NVM_WRITE_CYC = NVM_WRITE_MS * (CLK_HZ / 1000);
  localparam int unsigned NVM_CNT_W     = 18;
  localparam int unsigned CONV_CYC_DEF  = 4000;
  localparam int unsigned CONV_CNT_W    = 12;

  // Temperature format
  localparam int unsigned TEMP_W   = 9;
  localparam logic [8:0]  TEMP_MAX = 9'h0FA;  // +125 C
  localparam logic [8:0]  TEMP_MIN = 9'h192;  // -55 C

  // Bus addressing and commands
  localparam logic [3:0] CTRL_CODE      = 4'h9;
  localparam logic [7:0] CMD_READ_TEMP  = 8'hAA;
  localparam logic [7:0] CMD_HIGH_THR   = 8'hA1;
  localparam logic [7:0] CMD_LOW_THR    = 8'hA2;
  localparam logic [7:0] CMD_CONFIG     = 8'hAC;
  localparam logic [7:0] CMD_BEGIN_CONV = 8'h51;
  localparam logic [7:0] CMD_HALT_CONV  = 8'h52;
  localparam logic [7:0] READ_FILL      = 8'hFF;

  // Configuration byte bit positions
  localparam int unsigned CFG_DONE_BIT = 7;
  localparam int unsigned CFG_HIGH_BIT = 6;
  localparam int unsigned CFG_LOW_BIT  = 5;
  localparam int unsigned CFG_NVB_BIT  = 4;
  localparam int unsigned CFG_POL_BIT  = 1;
  localparam int unsigned CFG_ONE_BIT  = 0;

  // Reset values of the stored settings
  localparam logic       POL_RST      = 1'b0;
  localparam logic       ONE_SHOT_RST = 1'b0;
  localparam logic [8:0] HIGH_THR_RST = 9'h050;
  localparam logic [8:0] LOW_THR_RST  = 9'h028;

  // Bus slave states
  typedef enum logic [2:0] {
    TTC_IDLE     = 3'b000,
    TTC_ADDR     = 3'b001,
    TTC_ACK_ADDR = 3'b010,
    TTC_WRITE    = 3'b011,
    TTC_ACK_WR   = 3'b100,
    TTC_READ     = 3'b101,
    TTC_READ_ACK = 3'b110,
    TTC_READ_GO  = 3'b111
  } ttc_slave_st_t;

  // Conversion engine states
  typedef enum logic {
    TTC_CE_IDLE = 1'b0,
    TTC_CE_CONV = 1'b1
  } ttc_conv_st_t;

  // Byte-level events from the bus slave
  typedef struct packed {
    logic       frame;  // Addressed frame opened
    logic       rw;     // Direction of that frame, 1 = read
    logic       wr;     // Byte received
    logic       rd;     // Next byte to send wanted
    logic [7:0] data;   // Received byte
  } ttc_bus_ev_t;

  // Signed compare of two temperature codes
  function automatic logic ttc_ge(input logic [8:0] a, input logic [8:0] b);
    return $signed(a) >= $signed(b);
  endfunction : ttc_ge

endpackage : ttc_pkg

`default_nettype wire

//--- rtl/ttc_bus_slave.sv
/*
 * Two-wire bus slave: oversamples clock and data pins, finds start and
 * stop, matches the control byte and turns bytes into events.
 * Assumes bus clock well below a tenth of the system clock.
 */
`timescale 1ns/100ps
`default_nettype none

module ttc_bus_slave
  import ttc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Bus pins and device select
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic [2:0]  sel,
  // Byte side
  input  wire logic [7:0]  tx_byte,
  output ttc_bus_ev_t      ev,
  output logic             sda_oe_n
);

  logic [2:0]    scl_s_q;
  logic [2:0]    sda_s_q;
  logic          scl_f_q;
  logic          sda_f_q;
  logic          scl_new;
  logic          sda_new;
  ttc_slave_st_t st_q;
  logic [3:0]    cnt_q;
  logic [7:0]    sh_q;
  logic [7:0]    out_q;
  logic          rw_q;

  // Three-stage synchronisers, first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_i};
      sda_s_q <= {sda_s_q[1:0], sda_i};
    end
  end

  // A change counts once stages two and three agree
  assign scl_new = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
  assign sda_new = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      scl_f_q <= scl_new;
      sda_f_q <= sda_new;
    end
  end

  // Byte engine; start and stop override any bit activity
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q     <= TTC_IDLE;
      cnt_q    <= 4'h0;
      sh_q     <= 8'h00;
      out_q    <= 8'h00;
      rw_q     <= 1'b0;
      sda_oe_n <= 1'b1;
      ev       <= '0;
    end else begin
      ev.frame <= 1'b0;
      ev.wr    <= 1'b0;
      ev.rd    <= 1'b0;
      if (scl_f_q && scl_new && sda_f_q && !sda_new) begin
        st_q     <= TTC_ADDR;
        cnt_q    <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (scl_f_q && scl_new && !sda_f_q && sda_new) begin
        st_q     <= TTC_IDLE;
        sda_oe_n <= 1'b1;
      end else if (scl_new && !scl_f_q) begin
        unique case (st_q)
          TTC_ADDR, TTC_WRITE: begin
            sh_q  <= {sh_q[6:0], sda_new};
            cnt_q <= cnt_q + 4'h1;
          end
          TTC_READ_ACK: begin
            // Master not acknowledging ends the read
            if (sda_new) begin
              st_q <= TTC_IDLE;
            end else begin
              st_q  <= TTC_READ_GO;
              ev.rd <= 1'b1;
            end
          end
          default: ;
        endcase
      end else if (!scl_new && scl_f_q) begin
        unique case (st_q)
          TTC_ADDR: begin
            if (cnt_q == 4'h8) begin
              if (sh_q[7:1] == {CTRL_CODE, sel}) begin
                st_q     <= TTC_ACK_ADDR;
                sda_oe_n <= 1'b0;
                rw_q     <= sh_q[0];
                ev.frame <= 1'b1;
                ev.rw    <= sh_q[0];
                ev.rd    <= sh_q[0];
              end else begin
                st_q <= TTC_IDLE;
              end
            end
          end
          TTC_WRITE: begin
            if (cnt_q == 4'h8) begin
              st_q     <= TTC_ACK_WR;
              sda_oe_n <= 1'b0;
              ev.wr    <= 1'b1;
              ev.data  <= sh_q;
            end
          end
          TTC_ACK_ADDR, TTC_ACK_WR, TTC_READ_GO: begin
            if (rw_q) begin
              st_q     <= TTC_READ;
              out_q    <= tx_byte;
              sda_oe_n <= tx_byte[7];
              cnt_q    <= 4'h1;
            end else begin
              st_q     <= TTC_WRITE;
              sda_oe_n <= 1'b1;
              cnt_q    <= 4'h0;
            end
          end
          TTC_READ: begin
            if (cnt_q == 4'h8) begin
              st_q     <= TTC_READ_ACK;
              sda_oe_n <= 1'b1;
            end else begin
              out_q    <= {out_q[6:0], 1'b0};
              sda_oe_n <= out_q[6];
              cnt_q    <= cnt_q + 4'h1;
            end
          end
          default: ;
        endcase
      end
    end
  end

endmodule : ttc_bus_slave

`default_nettype wire

//--- rtl/ttc_conv_engine.sv
/*
 * Conversion sequencer: idles until told to begin, times each
 * conversion, captures and clamps the converter's code.
 * Assumes sense_temp is produced on clk by the converter front end.
 */
`timescale 1ns/100ps
`default_nettype none

module ttc_conv_engine
  import ttc_pkg::*;
#(
  parameter logic [CONV_CNT_W-1:0] CONV_CYCLES = CONV_CYC_DEF[CONV_CNT_W-1:0]
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Control
  input  wire logic        begin_conv,
  input  wire logic        halt_conv,
  input  wire logic        one_shot,
  // Converter code and results
  input  wire logic [8:0]  sense_temp,
  output logic [8:0]       result,
  output logic             done_pulse,
  output logic             busy
);

  ttc_conv_st_t          st_q;
  logic [CONV_CNT_W-1:0] cnt_q;
  logic [8:0]            clamped;

  // Codes past the documented span are pinned to its ends
  always_comb begin
    clamped = sense_temp;
    if (ttc_ge(sense_temp, TEMP_MAX)) clamped = TEMP_MAX;
    if (!ttc_ge(sense_temp, TEMP_MIN)) clamped = TEMP_MIN;
  end

  assign busy = (st_q == TTC_CE_CONV);

  // Halt aborts at once; begin restarts even mid-conversion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= TTC_CE_IDLE;
      cnt_q      <= '0;
      result     <= 9'h000;
      done_pulse <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      if (halt_conv) begin
        st_q <= TTC_CE_IDLE;
      end else if (begin_conv) begin
        st_q  <= TTC_CE_CONV;
        cnt_q <= '0;
      end else if (st_q == TTC_CE_CONV) begin
        if (cnt_q == CONV_CYCLES - 1'b1) begin
          result     <= clamped;
          done_pulse <= 1'b1;
          cnt_q      <= '0;
          if (one_shot) st_q <= TTC_CE_IDLE;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

endmodule : ttc_conv_engine

`default_nettype wire

//--- rtl/ttc_top.sv
/*
 * Thermostat conversion control: command decoding over the two-wire
 * bus, thresholds, configuration and status byte, trip flags and the
 * thermostat output. Assumes open-drain pads resolved outside and an
 * analog converter that delivers a code on sense_temp.
 */
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Readings are 9-bit, half-degree two's complement.
// - Second byte: half bit on top, rest zero.
// - One or two bytes may be transferred.
// - Readings clamp to -55 to +125 degrees.
// - Idle after reset until begin command.
// - Continuous mode runs until halt command.
// - Begin command restarts conversions any time.
// - One-shot: one conversion per begin command.
// - Config bit 0 selects one-shot, stored.
// - Thermostat re-evaluated at each conversion end.
// - Active at or above high, off below low.
// - Config bit 1 sets output polarity, stored.
// - Bit 7 reads done, zero while converting.
// - Bit 6 high flag sticky until written 0.
// - Bit 5 low flag sticky until written 0.
// - Bit 4 busy during stored-setting write.
// - One-shot output holds last conversion's level.
// - Thresholds share the temperature format.
// - Command AAh returns latest result, two bytes.
// - Command A1h writes or reads high threshold.
// - Command ACh writes or reads config byte.
module ttc_top
  import ttc_pkg::*;
#(
  parameter logic [NVM_CNT_W-1:0]  NVM_WRITE_CYCLES =
    NVM_WRITE_CYC[NVM_CNT_W-1:0],
  parameter logic [CONV_CNT_W-1:0] CONV_CYCLES =
    CONV_CYC_DEF[CONV_CNT_W-1:0]
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Two-wire bus pins
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  // Device select straps
  input  wire logic        select_bit_2,
  input  wire logic        select_bit_1,
  input  wire logic        select_bit_0,
  // Converter code
  input  wire logic [8:0]  sense_temp,
  // Thermostat pin
  output logic             tout
);

  ttc_bus_ev_t          ev;
  logic [8:0]           sel_s_q;
  logic [2:0]           sel_q;
  logic [7:0]           cmd_q;
  logic [1:0]           idx_q;
  logic [1:0]           rd_idx_q;
  logic [7:0]           tx_q;
  logic [7:0]           rd_byte;
  logic                 rd_first;
  logic [8:0]           high_threshold_q;
  logic [8:0]           low_threshold_q;
  logic                 output_polarity_q;
  logic                 single_conversion_select_q;
  logic                 high_trip_flag_q;
  logic                 low_trip_flag_q;
  logic                 active_q;
  logic [NVM_CNT_W-1:0] nvm_cnt_q;
  logic                 nvm_write_busy;
  logic                 nvm_start;
  logic                 cfg_wr;
  logic [7:0]           cfg_byte;
  logic                 begin_conv;
  logic                 halt_conv;
  logic [8:0]           result;
  logic                 conv_done;
  logic                 conv_busy;

  // Straps pass three stages; a change counts when two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_s_q <= 9'h000;
      sel_q   <= 3'h0;
    end else begin
      sel_s_q <= {sel_s_q[5:0], select_bit_2, select_bit_1, select_bit_0};
      for (int i = 0; i < 3; i++) begin
        if (sel_s_q[3+i] == sel_s_q[6+i]) sel_q[i] <= sel_s_q[6+i];
      end
    end
  end

  ttc_bus_slave u_slave (
    .clk      (clk),
    .rst_n    (rst_n),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .sel      (sel_q),
    .tx_byte  (tx_q),
    .ev       (ev),
    .sda_oe_n (sda_oe_n)
  );

  ttc_conv_engine #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_conv (
    .clk        (clk),
    .rst_n      (rst_n),
    .begin_conv (begin_conv),
    .halt_conv  (halt_conv),
    .one_shot   (single_conversion_select_q),
    .sense_temp (sense_temp),
    .result     (result),
    .done_pulse (conv_done),
    .busy       (conv_busy)
  );

  // Clock line is never stretched; data line only ever pulled low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_o    <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_o    <= 1'b0;
    end else begin
      scl_o    <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_o    <= 1'b0;
    end
  end

  // Command byte is the first byte written after the control byte
  assign begin_conv = ev.wr && (idx_q == 2'd0)
                      && (ev.data == CMD_BEGIN_CONV);
  assign halt_conv  = ev.wr && (idx_q == 2'd0)
                      && (ev.data == CMD_HALT_CONV);
  assign cfg_wr     = ev.wr && (idx_q == 2'd1) && (cmd_q == CMD_CONFIG);

  // Byte position within a write frame, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= 8'h00;
      idx_q <= 2'd0;
    end else if (ev.frame) begin
      idx_q <= 2'd0;
    end else if (ev.wr) begin
      if (idx_q == 2'd0) cmd_q <= ev.data;
      if (idx_q != 2'd3) idx_q <= idx_q + 2'd1;
    end
  end

  // Thresholds: first byte gives whole degrees, second the half bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_threshold_q <= HIGH_THR_RST;
      low_threshold_q  <= LOW_THR_RST;
    end else if (ev.wr) begin
      if (cmd_q == CMD_HIGH_THR) begin
        if (idx_q == 2'd1) high_threshold_q <= {ev.data, 1'b0};
        if (idx_q == 2'd2) high_threshold_q[0] <= ev.data[7];
      end
      if (cmd_q == CMD_LOW_THR) begin
        if (idx_q == 2'd1) low_threshold_q <= {ev.data, 1'b0};
        if (idx_q == 2'd2) low_threshold_q[0] <= ev.data[7];
      end
    end
  end

  // Stored mode bits; reserved bits 3 and 2 have no storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_polarity_q          <= POL_RST;
      single_conversion_select_q <= ONE_SHOT_RST;
    end else if (cfg_wr) begin
      output_polarity_q          <= ev.data[CFG_POL_BIT];
      single_conversion_select_q <= ev.data[CFG_ONE_BIT];
    end
  end

  // Every threshold or config write models a stored-memory copy
  assign nvm_start = ev.wr && (idx_q != 2'd0)
                     && ((cmd_q == CMD_HIGH_THR) || (cmd_q == CMD_LOW_THR)
                         || (cmd_q == CMD_CONFIG && idx_q == 2'd1));
  assign nvm_write_busy = (nvm_cnt_q != '0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nvm_cnt_q <= '0;
    end else if (nvm_start) begin
      nvm_cnt_q <= NVM_WRITE_CYCLES;
    end else if (nvm_write_busy) begin
      nvm_cnt_q <= nvm_cnt_q - 1'b1;
    end
  end

  // Hysteresis: between the thresholds the last state holds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 1'b0;
    end else if (conv_done) begin
      if (ttc_ge(result, high_threshold_q)) begin
        active_q <= 1'b1;
      end else if (!ttc_ge(result, low_threshold_q)) begin
        active_q <= 1'b0;
      end
    end
  end

  // Pin level follows polarity at once, even with no new conversion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tout <= ~POL_RST;
    end else begin
      tout <= ~(active_q ^ output_polarity_q);
    end
  end

  // Sticky flags: a trip in the clearing cycle wins over the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_trip_flag_q <= 1'b0;
      low_trip_flag_q  <= 1'b0;
    end else begin
      high_trip_flag_q <= (high_trip_flag_q
                           && !(cfg_wr && !ev.data[CFG_HIGH_BIT]))
                          || (conv_done
                              && ttc_ge(result, high_threshold_q));
      low_trip_flag_q  <= (low_trip_flag_q
                           && !(cfg_wr && !ev.data[CFG_LOW_BIT]))
                          || (conv_done
                              && ttc_ge(low_threshold_q, result));
    end
  end

  // Status view; bits 3 and 2 always zero
  always_comb begin
    cfg_byte               = 8'h00;
    cfg_byte[CFG_DONE_BIT] = !conv_busy;
    cfg_byte[CFG_HIGH_BIT] = high_trip_flag_q;
    cfg_byte[CFG_LOW_BIT]  = low_trip_flag_q;
    cfg_byte[CFG_NVB_BIT]  = nvm_write_busy;
    cfg_byte[CFG_POL_BIT]  = output_polarity_q;
    cfg_byte[CFG_ONE_BIT]  = single_conversion_select_q;
  end

  // A new read frame starts at byte 0, whatever the last frame left
  assign rd_first = ev.frame || (rd_idx_q == 2'd0);

  // Read data chosen by the last command and the byte position
  always_comb begin
    rd_byte = READ_FILL;
    unique case (cmd_q)
      CMD_READ_TEMP:
        rd_byte = rd_first ? result[8:1] : {result[0], 7'h00};
      CMD_HIGH_THR:
        rd_byte = rd_first ? high_threshold_q[8:1]
                           : {high_threshold_q[0], 7'h00};
      CMD_LOW_THR:
        rd_byte = rd_first ? low_threshold_q[8:1]
                           : {low_threshold_q[0], 7'h00};
      CMD_CONFIG:
        rd_byte = cfg_byte;
      default:
        rd_byte = READ_FILL;
    endcase
  end

  // Next transmit byte is fetched when the slave asks for it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q     <= 8'h00;
      rd_idx_q <= 2'd0;
    end else if (ev.rd) begin
      tx_q     <= rd_byte;
      rd_idx_q <= (ev.frame || rd_idx_q == 2'd0) ? 2'd1 : 2'd2;
      if (ev.frame) tx_q <= rd_byte;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  high_trip_a: assert property (conv_done
    && ttc_ge(result, high_threshold_q) |=> active_q ##1 high_trip_flag_q)
    else $error("High threshold not tripped");
  low_release_a: assert property (conv_done
    && !ttc_ge(result, low_threshold_q)
    && !ttc_ge(result, high_threshold_q) |=> !active_q)
    else $error("Low threshold did not release");
  hold_level_a: assert property (!conv_done |=> $stable(active_q))
    else $error("Thermostat changed without conversion");
  low_flag_a: assert property (conv_done
    && ttc_ge(low_threshold_q, result) |=> low_trip_flag_q [*2])
    else $error("Low flag not held");
  pin_polarity_a: assert property (tout == ($past(active_q)
    == $past(output_polarity_q)))
    else $error("Thermostat pin polarity wrong");
  done_bit_a: assert property (begin_conv && !halt_conv
    |=> !cfg_byte[CFG_DONE_BIT])
    else $error("Done bit high while converting");
  nvm_busy_a: assert property (nvm_start |=> nvm_write_busy [*8])
    else $error("Store busy flag missing");
  idle_stay_a: assert property (!conv_busy && !begin_conv |=> !conv_busy)
    else $error("Conversion started uncommanded");
  halt_stop_a: assert property (halt_conv |=> !conv_busy ##1 !conv_done)
    else $error("Halt did not stop conversions");
  span_a: assert property (conv_done |-> ttc_ge(result, TEMP_MIN)
    && ttc_ge(TEMP_MAX, result))
    else $error("Result outside span");
  reserved_a: assert property (cfg_byte[3:2] == 2'b00)
    else $error("Reserved bits not zero");

  high_trip_c: cover property (conv_done ##1 active_q && high_trip_flag_q);
  one_shot_c: cover property (single_conversion_select_q && conv_done
    ##1 !conv_busy);
  read_frame_c: cover property (ev.frame && ev.rw ##[1:1000] ev.rd);
  flag_clear_c: cover property (high_trip_flag_q ##1 !high_trip_flag_q);

endmodule : ttc_top

`default_nettype wire

//--- test/ttc_bus_master.sv
/* Two-wire bus master model: frames, bytes, acknowledges.
   Assumes pull-ups on both lines and a 20 MHz clk; 1 releases a line. */
`timescale 1ns/100ps
`default_nettype none
module ttc_bus_master (
  // Clock and resolved data line
  input  wire logic       clk,
  input  wire logic       sda,
  // Pin drive, clock stands high outside frames
  output logic            scl_m,
  output logic            sda_m,
  // Byte read strobe
  output logic            got,
  output logic [7:0]      rx
);
  initial {scl_m, sda_m, got, rx} = 11'h600;
  // Quarter bit, slow against the slave's filters
  task automatic qb;
    repeat (10) @(negedge clk);
  endtask : qb
  // START or repeated START
  task automatic start;
    sda_m = 1'b1;
    qb;
    scl_m = 1'b1;
    qb;
    sda_m = 1'b0;
    qb;
    scl_m = 1'b0;
    qb;
  endtask : start
  task automatic stop;
    sda_m = 1'b0;
    qb;
    scl_m = 1'b1;
    qb;
    sda_m = 1'b1;
    qb;
  endtask : stop
  // One bit, data changes only while the clock is low
  task automatic bit_x(input logic b, output logic r);
    sda_m = b;
    qb;
    scl_m = 1'b1;
    qb;
    r = sda;
    qb;
    scl_m = 1'b0;
    qb;
  endtask : bit_x
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, ack);
  endtask : wbyte
  // Last byte gets no acknowledge
  task automatic rbyte(input logic last);
    logic [7:0] b;
    logic       r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
    bit_x(last, r);
    rx = b;
    got = 1'b1;
    @(negedge clk);
    got = 1'b0;
  endtask : rbyte
endmodule : ttc_bus_master
`default_nettype wire

//--- test/ttc_top_bench.sv
/* Bench for the thermostat block: config, thresholds, conversions.
   Assumes the bus master model; inputs change on falling clk edges. */
`timescale 1ns/100ps
`default_nettype none
module ttc_top_bench;
  import ttc_pkg::*;
  logic [2:0] sel = 3'b101;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [8:0] sense = 9'h000;
  logic       scl_o, scl_oe_n, sda_o, sda_oe_n, tout, scl_m, sda_m, got, ack;
  logic [7:0] rx;
  logic [7:0] q[$];
  logic [8:0] hi_t = 9'h033, lo_t = 9'h014, t;
  logic       act = 1'b0, fh = 1'b0, fl = 1'b0;
  int         failures = 0, compares = 0, cyc = 0, seed = 48004, r;
  // Open-drain wires, pulled up
  wire scl_w = scl_m & (scl_oe_n | scl_o);
  wire sda_w = sda_m & (sda_oe_n | sda_o);
  always #25 clk = ~clk;
  ttc_top #(.NVM_WRITE_CYCLES(18'd3000), .CONV_CYCLES(12'd40)) ttc_top_inst (
    .clk(clk), .rst_n(rst_n), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .select_bit_2(sel[2]), .select_bit_1(sel[1]), .select_bit_0(sel[0]),
    .sense_temp(sense), .tout(tout));
  ttc_bus_master ttc_bus_master_inst (.clk(clk), .sda(sda_w), .scl_m(scl_m),
    .sda_m(sda_m), .got(got), .rx(rx));
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic final_report;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // Each byte read takes the oldest note
  always @(posedge clk) if (got) cmp("read byte", q.pop_front(), rx);
  // Hang guard, about three quarters again the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      failures++;
      final_report;
    end
  end
  // Write nw bytes of d after cmd, then read nr bytes back
  task automatic xfer(input logic [7:0] cmd, input int nw,
                      input logic [15:0] d, input int nr);
    ttc_bus_master_inst.start;
    ttc_bus_master_inst.wbyte({CTRL_CODE, sel, 1'b0}, ack);
    cmp("address ack", 8'h00, {7'h00, ack});
    ttc_bus_master_inst.wbyte(cmd, ack);
    for (int i = 0; i < nw; i++) ttc_bus_master_inst.wbyte(d[15-8*i -: 8], ack);
    if (nr > 0) begin
      ttc_bus_master_inst.start;
      ttc_bus_master_inst.wbyte({CTRL_CODE, sel, 1'b1}, ack);
      for (int i = 0; i < nr; i++) ttc_bus_master_inst.rbyte(i == nr - 1);
    end
    ttc_bus_master_inst.stop;
  endtask : xfer
  task automatic note_t(input logic [8:0] v);
    q.push_back(v[8:1]);
    q.push_back({v[0], 7'h00});
  endtask : note_t
  // One conversion with the hysteresis model; polarity is 1 here
  task automatic conv(input logic [8:0] s);
    sense = s;
    xfer(CMD_BEGIN_CONV, 0, 16'h0000, 0);
    repeat (200) @(negedge clk);
    t = $signed(s) > $signed(TEMP_MAX) ? TEMP_MAX :
        $signed(s) < $signed(TEMP_MIN) ? TEMP_MIN : s;
    if ($signed(t) >= $signed(hi_t)) act = 1'b1;
    else if ($signed(t) < $signed(lo_t)) act = 1'b0;
    fh |= $signed(t) >= $signed(hi_t);
    fl |= $signed(t) <= $signed(lo_t);
    cmp("tout", {7'h00, act}, {7'h00, tout});
  endtask : conv
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    cmp("tout idle", 8'h01, {7'h00, tout});
    q.push_back(8'h80);
    xfer(CMD_CONFIG, 0, 16'h0000, 1);
    xfer(CMD_CONFIG, 1, 16'hFF00, 0);
    q.push_back(8'h93);
    xfer(CMD_CONFIG, 0, 16'h0000, 1);
    repeat (3000) @(negedge clk);
    q.push_back(8'h83);
    xfer(CMD_CONFIG, 0, 16'h0000, 1);
    xfer(CMD_HIGH_THR, 2, {hi_t, 7'h00}, 0);
    xfer(CMD_LOW_THR, 2, {lo_t, 7'h00}, 0);
    note_t(hi_t);
    xfer(CMD_HIGH_THR, 0, 16'h0000, 2);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      conv(i == 0 ? 9'h0FF : i == 1 ? 9'h100 : 9'(r % 181 + 70));
      note_t(t);
      xfer(CMD_READ_TEMP, 0, 16'h0000, 2);
    end
    // Straps move mid-run; later frames must follow the new address
    sel = 3'($random(seed));
    repeat (3100) @(negedge clk);
    q.push_back({1'b1, fh, fl, 5'h03});
    xfer(CMD_CONFIG, 0, 16'h0000, 1);
    xfer(CMD_CONFIG, 1, 16'h0300, 0);
    q.push_back(8'h93);
    xfer(CMD_CONFIG, 0, 16'h0000, 1);
    // Continuous mode follows the converter until halted
    xfer(CMD_CONFIG, 1, 16'h0200, 0);
    conv(9'h040);
    sense = 9'h1F0;
    repeat (300) @(negedge clk);
    note_t(9'h1F0);
    xfer(CMD_READ_TEMP, 0, 16'h0000, 2);
    xfer(CMD_HALT_CONV, 0, 16'h0000, 0);
    sense = 9'h060;
    repeat (300) @(negedge clk);
    note_t(9'h1F0);
    xfer(CMD_READ_TEMP, 0, 16'h0000, 2);
    // Another device's address gets no acknowledge
    ttc_bus_master_inst.start;
    ttc_bus_master_inst.wbyte({CTRL_CODE, ~sel, 1'b0}, ack);
    ttc_bus_master_inst.stop;
    cmp("foreign ack", 8'h01, {7'h00, ack});
    repeat (20) @(negedge clk);
    // A read that never came back leaves a note behind
    cmp("notes left", 8'h00, 8'(q.size()));
    cmp("pin drive", 8'h02, {5'h00, scl_o, scl_oe_n, sda_o});
    final_report;
  end
endmodule : ttc_top_bench
`default_nettype wire
